//--- src/frce_pkg.sv
/*
  Shared constants and types for the floppy read command engine.
  Assumes one 25 MHz clock domain and a separate disk data separator.
*/
package frce_pkg;
  // command block
  localparam logic [3:0] CMD_LEN = 4'h9;
  localparam int B_OP = 0;
  localparam int B_HD = 1;
  localparam int B_C = 2;
  localparam int B_H = 3;
  localparam int B_R = 4;
  localparam int B_N = 5;
  localparam int B_EOT = 6;
  localparam int B_DTL = 8;
  localparam int MT_BIT = 7;
  localparam int SK_BIT = 5;
  localparam int HD_BIT = 2;
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0C;
  localparam logic [4:0] OP_READ_TRK = 5'h02;
  // sector geometry
  localparam logic [14:0] SEC_BASE = 15'h0080;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  // status layout
  localparam logic [1:0] IC_OK = 2'h0;
  localparam logic [1:0] IC_ABN = 2'h1;
  localparam int ST0_IC = 6;
  localparam int ST0_HEAD = 2;
  localparam int ST1_MA = 0;
  localparam int ST1_ND = 2;
  localparam int ST1_DE = 5;
  localparam int ST2_DD = 5;
  localparam int ST2_CM = 6;

  typedef struct packed {
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
  } frce_id_t;

  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    frce_id_t id;
  } frce_result_t;

  typedef enum logic [2:0] {
    S_IDLE, S_SEEK, S_HEAD, S_SETTLE, S_INDEX, S_SCAN, S_DATA, S_FIN
  } frce_state_t;
endpackage : frce_pkg

//--- src/frce_read_engine.sv
/*
  Read-type command engine: read data, read deleted data, read track.
  Assumes a data separator that reports ID fields, data marks, data bytes
  and the data CRC verdict, and a host that collects result and FIFO bytes.
*/
// Functional notes
// - nine command bytes before execution starts
// - load head, wait settle, then scan IDs
// - matching sector data goes to FIFO
// - increment sector, continue multi-sector read
// - terminal count stops data, sector finishes
// - size code selects bytes per sector
// - size zero: data length limits transfer
// - nonzero size ignores data length
// - multi-track continues side 0 to 1
// - head stays loaded until unload time
// - two index pulses unmatched: no data
// - CRC error: abnormal, crc flags, terminate
// - deleted mark handling per skip flag
// - read deleted targets deleted marks
// - read track starts after index pulse
// - read track continues past CRC errors
// - read track flags ID mismatch
// - read track no ID mark: missing
// - result ID follows end-of-track table
// - implied seek first, failure reported
`timescale 1ns/10ps
module frce_read_engine #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // command bytes
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_byte_valid,
  // settings
  input wire logic [TW-1:0] settle_cycles,
  input wire logic [TW-1:0] unload_cycles,
  input wire logic implied_seek_en,
  // seek handshake
  output logic seek_req,
  output logic [7:0] seek_cyl,
  input wire logic seek_done,
  input wire logic seek_fail,
  // drive and separator
  input wire logic index_pulse_input,
  input wire logic id_valid,
  input wire logic id_crc_ok,
  input wire frce_pkg::frce_id_t id_field,
  input wire logic dam_valid,
  input wire logic dam_deleted,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic data_crc_valid,
  input wire logic data_crc_ok,
  // fifo side
  output logic fifo_push,
  output logic [7:0] fifo_data,
  input wire logic fifo_full,
  input wire logic terminal_count,
  // status
  output logic head_load,
  output logic busy,
  output logic res_valid,
  output frce_pkg::frce_result_t result
);
  frce_pkg::frce_state_t st_q;
  logic [7:0] cmd_q [frce_pkg::CMD_LEN];
  logic [3:0] cnt_q;
  logic [7:0] c_q, h_q, r_q, sect_q;
  logic [14:0] bcnt_q;
  logic [TW-1:0] timer_q;
  logic idx_q, id_seen_q, stop_q, dam_seen_q, skip_q, ctl_q;
  logic abn_q, nd_q, de_q, dd_q, ma_q, cm_q;
  logic fifo_push_q, seek_req_q, head_load_q, busy_q, res_valid_q;
  logic [7:0] fifo_data_q, seek_cyl_q;
  frce_pkg::frce_result_t result_q;

  wire logic [4:0] op_w = cmd_q[frce_pkg::B_OP][4:0];
  wire logic trk_w = op_w == frce_pkg::OP_READ_TRK;
  wire logic is_read_w = trk_w | (op_w == frce_pkg::OP_READ) | (op_w == frce_pkg::OP_READ_DEL);
  wire logic mt_w = cmd_q[frce_pkg::B_OP][frce_pkg::MT_BIT] & ~trk_w;
  wire logic sk_w = cmd_q[frce_pkg::B_OP][frce_pkg::SK_BIT] & ~trk_w;
  wire logic [7:0] n_w = cmd_q[frce_pkg::B_N];
  wire logic [7:0] eot_w = cmd_q[frce_pkg::B_EOT];
  wire logic [7:0] dtl_w = cmd_q[frce_pkg::B_DTL];
  wire logic [14:0] sec_size_w = frce_pkg::SEC_BASE << n_w[2:0];
  wire logic [14:0] xfer_lim_w = (n_w == 8'h00) ? {7'h00, dtl_w} : sec_size_w;
  wire logic id_match_w = id_field == {c_q, h_q, r_q, n_w};
  wire logic at_eot_w = r_q == eot_w;
  wire logic cont_w = ~at_eot_w | (mt_w & ~h_q[0]);
  wire logic [7:0] nxt_r_w = at_eot_w ? frce_pkg::FIRST_SECTOR : r_q + 8'h01;
  wire logic [7:0] nxt_h_w = (at_eot_w & mt_w) ? {h_q[7:1], ~h_q[0]} : h_q;
  wire logic [7:0] nxt_c_w = (at_eot_w & (~mt_w | h_q[0])) ? c_q + 8'h01 : c_q;
  // mark sense flips for read deleted
  wire logic mark_w = dam_deleted ^ (op_w == frce_pkg::OP_READ_DEL);
  wire logic push_w = (st_q == frce_pkg::S_DATA) & dam_seen_q & disk_byte_valid & ~stop_q & ~skip_q
    & (bcnt_q < xfer_lim_w);
  wire logic [7:0] sect_inc_w = sect_q + 8'h01;
  wire logic [7:0] st0_w = (8'(abn_q ? frce_pkg::IC_ABN : frce_pkg::IC_OK) << frce_pkg::ST0_IC)
    | (8'(cmd_q[frce_pkg::B_HD][frce_pkg::HD_BIT]) << frce_pkg::ST0_HEAD);
  wire logic [7:0] st1_w = (8'(de_q) << frce_pkg::ST1_DE) | (8'(nd_q) << frce_pkg::ST1_ND)
    | (8'(ma_q) << frce_pkg::ST1_MA);
  wire logic [7:0] st2_w = (8'(cm_q) << frce_pkg::ST2_CM) | (8'(dd_q) << frce_pkg::ST2_DD);
  wire frce_pkg::frce_state_t first_st_w = trk_w ? frce_pkg::S_INDEX : frce_pkg::S_SCAN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= frce_pkg::S_IDLE;
      for (int i = 0; i < int'(frce_pkg::CMD_LEN); i++) begin
        cmd_q[i] <= 8'h00;
      end
      cnt_q <= 4'h0;
      {c_q, h_q, r_q, sect_q} <= 32'h0000_0000;
      bcnt_q <= 15'h0000;
      timer_q <= '0;
      {idx_q, id_seen_q, stop_q, dam_seen_q, skip_q, ctl_q} <= 6'h00;
      {abn_q, nd_q, de_q, dd_q, ma_q, cm_q} <= 6'h00;
      {fifo_push_q, seek_req_q, head_load_q, busy_q, res_valid_q} <= 5'h00;
      fifo_data_q <= 8'h00;
      seek_cyl_q <= 8'h00;
      result_q <= '0;
    end else if (ce) begin
      fifo_push_q <= push_w;
      if (push_w) begin
        fifo_data_q <= disk_byte;
      end
      res_valid_q <= 1'b0;
      seek_req_q <= 1'b0;
      if (dam_seen_q && disk_byte_valid) begin
        bcnt_q <= bcnt_q + 15'h0001;
      end
      if (busy_q && (terminal_count || (push_w && fifo_full))) begin
        stop_q <= 1'b1;
      end
      case (st_q)
        frce_pkg::S_IDLE: begin
          if (timer_q != '0) begin
            timer_q <= timer_q - 1'b1;
          end else begin
            head_load_q <= 1'b0;
          end
          if (cmd_byte_valid && cnt_q < frce_pkg::CMD_LEN) begin
            cmd_q[cnt_q] <= cmd_byte;
            cnt_q <= cnt_q + 4'h1;
          end else if (cnt_q == frce_pkg::CMD_LEN) begin
            cnt_q <= 4'h0;
            if (is_read_w) begin
              busy_q <= 1'b1;
              {idx_q, id_seen_q, stop_q, abn_q, nd_q, de_q, dd_q, ma_q, cm_q} <= 9'h000;
              c_q <= cmd_q[frce_pkg::B_C];
              h_q <= cmd_q[frce_pkg::B_H];
              r_q <= cmd_q[frce_pkg::B_R];
              sect_q <= 8'h00;
              seek_req_q <= implied_seek_en;
              seek_cyl_q <= cmd_q[frce_pkg::B_C];
              st_q <= implied_seek_en ? frce_pkg::S_SEEK : frce_pkg::S_HEAD;
            end
          end
        end
        frce_pkg::S_SEEK: begin
          if (seek_done) begin
            abn_q <= seek_fail;
            st_q <= seek_fail ? frce_pkg::S_FIN : frce_pkg::S_HEAD;
          end
        end
        frce_pkg::S_HEAD: begin
          if (head_load_q) begin
            st_q <= first_st_w;
          end else begin
            head_load_q <= 1'b1;
            timer_q <= settle_cycles;
            st_q <= frce_pkg::S_SETTLE;
          end
        end
        frce_pkg::S_SETTLE: begin
          if (timer_q == '0) begin
            st_q <= first_st_w;
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        frce_pkg::S_INDEX: begin
          // start at index, counts as first
          if (index_pulse_input) begin
            idx_q <= 1'b1;
            st_q <= frce_pkg::S_SCAN;
          end
        end
        frce_pkg::S_SCAN: begin
          {dam_seen_q, skip_q, ctl_q} <= 3'h0;
          bcnt_q <= 15'h0000;
          if (id_valid) begin
            id_seen_q <= 1'b1;
            if (!id_crc_ok) begin
              de_q <= 1'b1;
              dd_q <= 1'b1;
              if (!trk_w) begin
                abn_q <= 1'b1;
                st_q <= frce_pkg::S_FIN;
              end
            end else if (trk_w) begin
              if (!id_match_w) begin
                nd_q <= 1'b1;
              end
              st_q <= frce_pkg::S_DATA;
            end else if (id_match_w) begin
              st_q <= frce_pkg::S_DATA;
            end
          end else if (index_pulse_input) begin
            idx_q <= 1'b1;
            if (idx_q) begin
              st_q <= frce_pkg::S_FIN;
              abn_q <= ~(trk_w & id_seen_q);
              ma_q <= trk_w & ~id_seen_q;
              nd_q <= nd_q | ~trk_w;
            end
          end
        end
        frce_pkg::S_DATA: begin
          if (dam_valid && !dam_seen_q) begin
            dam_seen_q <= 1'b1;
            ctl_q <= mark_w & ~trk_w;
            if (mark_w && !trk_w) begin
              cm_q <= 1'b1;
              skip_q <= sk_w;
            end
          end
          if (data_crc_valid) begin
            if (trk_w) begin
              de_q <= de_q | ~data_crc_ok;
              sect_q <= sect_inc_w;
              r_q <= r_q + 8'h01;
              st_q <= (stop_q || sect_inc_w == eot_w) ? frce_pkg::S_FIN : frce_pkg::S_SCAN;
            end else if (!data_crc_ok) begin
              de_q <= 1'b1;
              abn_q <= 1'b1;
              st_q <= frce_pkg::S_FIN;
            end else if (ctl_q && !sk_w) begin
              st_q <= frce_pkg::S_FIN;
            end else begin
              c_q <= nxt_c_w;
              h_q <= nxt_h_w;
              r_q <= nxt_r_w;
              idx_q <= 1'b0;
              st_q <= (stop_q || !cont_w) ? frce_pkg::S_FIN : frce_pkg::S_SCAN;
            end
          end
        end
        frce_pkg::S_FIN: begin
          busy_q <= 1'b0;
          res_valid_q <= 1'b1;
          result_q <= {st0_w, st1_w, st2_w, c_q, h_q, r_q, n_w};
          timer_q <= unload_cycles;
          stop_q <= 1'b0;
          st_q <= frce_pkg::S_IDLE;
        end
        default: st_q <= frce_pkg::S_IDLE;
      endcase
    end
  end

  assign seek_req = seek_req_q;
  assign seek_cyl = seek_cyl_q;
  assign fifo_push = fifo_push_q;
  assign fifo_data = fifo_data_q;
  assign head_load = head_load_q;
  assign busy = busy_q;
  assign res_valid = res_valid_q;
  assign result = result_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_two_live(logic t);
    (t && ce) ##1 ce;
  endsequence

  property p_start_nine;
    ($past(st_q) == frce_pkg::S_IDLE && st_q != frce_pkg::S_IDLE) |-> $past(cnt_q) == frce_pkg::CMD_LEN;
  endproperty
  a_start_nine: assert property (p_start_nine) else $error("started before nine bytes");

  property p_settle_loaded;
    st_q == frce_pkg::S_SETTLE |-> head_load_q;
  endproperty
  a_settle_loaded: assert property (p_settle_loaded) else $error("settling with head unloaded");

  property p_stop_no_push;
    fifo_push_q |-> $past(!stop_q && st_q == frce_pkg::S_DATA);
  endproperty
  a_stop_no_push: assert property (p_stop_no_push) else $error("push after stop");

  property p_limit;
    fifo_push_q |-> $past(bcnt_q) < $past(xfer_lim_w);
  endproperty
  a_limit: assert property (p_limit) else $error("push beyond transfer limit");

  property p_hold_head;
    (st_q == frce_pkg::S_IDLE && head_load_q && timer_q != '0) |=> head_load_q;
  endproperty
  a_hold_head: assert property (p_hold_head) else $error("head dropped early");

  property p_nd_abn;
    (res_valid_q && result_q.st1[frce_pkg::ST1_ND] && !trk_w)
      |-> result_q.st0[7:6] == frce_pkg::IC_ABN;
  endproperty
  a_nd_abn: assert property (p_nd_abn) else $error("no data without abnormal code");

  property p_eot_result;
    s_two_live(st_q == frce_pkg::S_DATA && data_crc_valid && data_crc_ok && !trk_w && !ctl_q && !cont_w)
      |=> res_valid_q && result_q.id.r == frce_pkg::FIRST_SECTOR;
  endproperty
  a_eot_result: assert property (p_eot_result) else $error("end of track result sector wrong");

  property p_id_crc;
    s_two_live(st_q == frce_pkg::S_SCAN && id_valid && !id_crc_ok && !trk_w)
      |=> res_valid_q && result_q.st0[7:6] == frce_pkg::IC_ABN && result_q.st2[frce_pkg::ST2_DD];
  endproperty
  a_id_crc: assert property (p_id_crc) else $error("id crc error not reported");
endmodule : frce_read_engine

//--- verification/frce_drive_model.sv
/*
  Behavioural drive plus data separator feeding the read engine.
  Assumes the bench calls its tasks and that clk is the engine's clock.
*/
`timescale 1ns/10ps
module frce_drive_model (
  // clock
  input wire logic clk,
  // separator outputs
  output logic index_pulse_input,
  output logic id_valid,
  output logic id_crc_ok,
  output frce_pkg::frce_id_t id_field,
  output logic dam_valid,
  output logic dam_deleted,
  output logic disk_byte_valid,
  output logic [7:0] disk_byte,
  output logic data_crc_valid,
  output logic data_crc_ok
);
  initial begin
    index_pulse_input = 1'b0;
    id_valid = 1'b0;
    id_crc_ok = 1'b0;
    id_field = 32'h0000_0000;
    dam_valid = 1'b0;
    dam_deleted = 1'b0;
    disk_byte_valid = 1'b0;
    disk_byte = 8'h00;
    data_crc_valid = 1'b0;
    data_crc_ok = 1'b0;
  end

  task automatic index_mark();
    @(posedge clk);
    index_pulse_input <= 1'b1;
    @(posedge clk);
    index_pulse_input <= 1'b0;
  endtask : index_mark

  // qualifiers are inverted outside their pulse so stale values never look valid
  task automatic sector(input frce_pkg::frce_id_t id, input logic id_ok, input logic del, input int len,
                        input logic crc_ok);
    @(posedge clk);
    id_valid <= 1'b1;
    id_field <= id;
    id_crc_ok <= id_ok;
    @(posedge clk);
    id_valid <= 1'b0;
    id_field <= ~id;
    id_crc_ok <= ~id_ok;
    @(posedge clk);
    dam_valid <= 1'b1;
    dam_deleted <= del;
    @(posedge clk);
    dam_valid <= 1'b0;
    dam_deleted <= ~del;
    for (int k = 0; k < len; k++) begin
      disk_byte_valid <= 1'b1;
      disk_byte <= k[7:0] ^ 8'h5A;
      @(posedge clk);
    end
    disk_byte_valid <= 1'b0;
    disk_byte <= disk_byte ^ 8'hFF;
    data_crc_valid <= 1'b1;
    data_crc_ok <= crc_ok;
    @(posedge clk);
    data_crc_valid <= 1'b0;
    data_crc_ok <= ~crc_ok;
    repeat (3) @(posedge clk);
  endtask : sector
endmodule : frce_drive_model

//--- verification/tb.sv
/*
  Self-checking bench for the read command engine.
  Assumes the drive model stands in for the disk and the bench acts as host.
*/
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_byte_valid = 1'b0;
  logic implied_seek_en = 1'b0;
  logic fifo_full = 1'b0;
  bit res_seen = 1'b0;
  logic seek_req, seek_done = 1'b0, seek_fail = 1'b0, terminal_count = 1'b0;
  logic [7:0] seek_cyl, fifo_data, disk_byte;
  logic index_pulse_input, id_valid, id_crc_ok, dam_valid, dam_deleted, disk_byte_valid;
  logic data_crc_valid, data_crc_ok, fifo_push, head_load, busy, res_valid;
  frce_pkg::frce_id_t id_field;
  frce_pkg::frce_result_t result;
  int num_errors = 0, samples_checked = 0, pushes = 0, cycles = 0;

  always #20 clk = ~clk;

  frce_read_engine #(.TW(16)) DUT (.clk(clk), .rst(rst), .ce(1'b1), .cmd_byte(cmd_byte),
    .cmd_byte_valid(cmd_byte_valid), .settle_cycles(16'h0004), .unload_cycles(16'h0020),
    .implied_seek_en(implied_seek_en), .seek_req(seek_req), .seek_cyl(seek_cyl), .seek_done(seek_done),
    .seek_fail(seek_fail), .index_pulse_input(index_pulse_input), .id_valid(id_valid),
    .id_crc_ok(id_crc_ok), .id_field(id_field), .dam_valid(dam_valid), .dam_deleted(dam_deleted),
    .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte), .data_crc_valid(data_crc_valid),
    .data_crc_ok(data_crc_ok), .fifo_push(fifo_push), .fifo_data(fifo_data), .fifo_full(fifo_full),
    .terminal_count(terminal_count), .head_load(head_load), .busy(busy), .res_valid(res_valid),
    .result(result));

  frce_drive_model drv (.clk(clk), .index_pulse_input(index_pulse_input), .id_valid(id_valid),
    .id_crc_ok(id_crc_ok), .id_field(id_field), .dam_valid(dam_valid), .dam_deleted(dam_deleted),
    .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte), .data_crc_valid(data_crc_valid),
    .data_crc_ok(data_crc_ok));

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // hang guard: the whole run needs well under 20000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // result strobe lasts one cycle; latch it so a busy scenario cannot miss it
  always @(negedge clk) begin
    if (res_valid === 1'b1) begin
      res_seen = 1'b1;
    end
    if (fifo_push === 1'b1) begin
      chk("fifo_data", pushes[7:0] ^ 8'h5A, fifo_data);
      pushes++;
    end
  end

  task automatic send_cmd(input logic [7:0] b0, b1, b2, b3, b4, b5, b6, b8);
    logic [7:0] seq [9];
    seq = '{b0, b1, b2, b3, b4, b5, b6, 8'h1B, b8};
    pushes = 0;
    res_seen = 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      cmd_byte_valid <= 1'b1;
      cmd_byte <= seq[i];
    end
    @(posedge clk);
    cmd_byte_valid <= 1'b0;
  endtask : send_cmd

  task automatic start(input logic [7:0] b0, b1, b2, b3, b4, b5, b6, b8);
    send_cmd(b0, b1, b2, b3, b4, b5, b6, b8);
    repeat (10) @(negedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    chk("head_load", 8'h01, {7'h00, head_load});
  endtask : start

  task automatic chk_res(input logic [1:0] ic, input logic [7:0] s1, s2);
    int n;
    n = 0;
    while (!res_seen && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("res_valid", 8'h01, {7'h00, res_seen});
    res_seen = 1'b0;
    chk("completion_code", {6'h00, ic}, {6'h00, result.st0[7:6]});
    chk("status_one", s1, result.st1);
    chk("status_two", s2, result.st2);
  endtask : chk_res

  task automatic chk_id(input logic [7:0] c, h, r);
    chk("result_c", c, result.id.c);
    chk("result_h", h, result.id.h);
    chk("result_r", r, result.id.r);
    repeat (8) @(posedge clk);
  endtask : chk_id

  task automatic t_short_dtl();
    start(8'h06, 8'h00, 8'h0A, 8'h00, 8'h03, 8'h00, 8'h03, 8'h04);
    drv.sector('{8'h0A, 8'h00, 8'h03, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk("push_count", 8'h04, pushes[7:0]);
    chk_id(8'h0B, 8'h00, 8'h01);
  endtask : t_short_dtl

  task automatic t_multi_sector();
    start(8'h06, 8'h00, 8'h02, 8'h00, 8'h01, 8'h01, 8'h02, 8'hFF);
    drv.sector('{8'h02, 8'h00, 8'h01, 8'h01}, 1'b1, 1'b0, 256, 1'b1);
    drv.sector('{8'h02, 8'h00, 8'h02, 8'h01}, 1'b1, 1'b0, 256, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk("push_count", 8'h01, {7'h00, pushes == 512});
    chk_id(8'h03, 8'h00, 8'h01);
  endtask : t_multi_sector

  task automatic t_data_crc();
    start(8'h06, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00, 8'h04, 8'hFF);
    drv.sector('{8'h01, 8'h00, 8'h04, 8'h00}, 1'b1, 1'b0, 128, 1'b0);
    chk_res(frce_pkg::IC_ABN, 8'h20, 8'h00);
    repeat (8) @(posedge clk);
  endtask : t_data_crc

  task automatic t_no_data();
    start(8'h06, 8'h00, 8'h01, 8'h00, 8'h07, 8'h00, 8'h07, 8'hFF);
    drv.sector('{8'h01, 8'h00, 8'h06, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
    drv.index_mark();
    drv.sector('{8'h01, 8'h00, 8'h08, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
    drv.index_mark();
    chk_res(frce_pkg::IC_ABN, 8'h04, 8'h00);
    repeat (8) @(posedge clk);
  endtask : t_no_data

  task automatic t_deleted_noskip();
    start(8'h06, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h09, 8'h08);
    drv.sector('{8'h01, 8'h00, 8'h05, 8'h00}, 1'b1, 1'b1, 128, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h40);
    chk("push_count", 8'h08, pushes[7:0]);
    chk_id(8'h01, 8'h00, 8'h05);
  endtask : t_deleted_noskip

  task automatic t_terminal_count();
    start(8'h06, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'h09, 8'hFF);
    fork
      drv.sector('{8'h01, 8'h00, 8'h03, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
      begin
        wait (pushes >= 10);
        @(posedge clk);
        terminal_count <= 1'b1;
      end
    join
    @(posedge clk);
    terminal_count <= 1'b0;
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk("push_count", 8'h01, {7'h00, pushes <= 13});
    chk_id(8'h01, 8'h00, 8'h04);
  endtask : t_terminal_count

  task automatic t_track_missing();
    start(8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h09, 8'hFF);
    drv.index_mark();
    repeat (20) @(posedge clk);
    drv.index_mark();
    chk_res(frce_pkg::IC_ABN, 8'h01, 8'h00);
    repeat (8) @(posedge clk);
  endtask : t_track_missing

  task automatic t_seek_fail();
    int n;
    implied_seek_en <= 1'b1;
    send_cmd(8'h06, 8'h00, 8'h15, 8'h00, 8'h01, 8'h00, 8'h01, 8'hFF);
    n = 0;
    while (seek_req !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("seek_req", 8'h01, {7'h00, seek_req});
    chk("seek_cyl", 8'h15, seek_cyl);
    @(posedge clk);
    seek_done <= 1'b1;
    seek_fail <= 1'b1;
    @(posedge clk);
    seek_done <= 1'b0;
    seek_fail <= 1'b0;
    implied_seek_en <= 1'b0;
    chk_res(frce_pkg::IC_ABN, 8'h00, 8'h00);
    chk("result_c", 8'h15, result.id.c);
    repeat (8) @(posedge clk);
  endtask : t_seek_fail

  task automatic t_multi_track_head1();
    start(8'h86, 8'h04, 8'h04, 8'h01, 8'h02, 8'h00, 8'h02, 8'h02);
    drv.sector('{8'h04, 8'h01, 8'h02, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk_id(8'h05, 8'h00, 8'h01);
  endtask : t_multi_track_head1

  task automatic t_multi_track_side0();
    start(8'h86, 8'h00, 8'h04, 8'h00, 8'h01, 8'h01, 8'h01, 8'hFF);
    drv.sector('{8'h04, 8'h00, 8'h01, 8'h01}, 1'b1, 1'b0, 256, 1'b1);
    drv.sector('{8'h04, 8'h01, 8'h01, 8'h01}, 1'b1, 1'b0, 256, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk("push_count", 8'h01, {7'h00, pushes == 512});
    chk_id(8'h05, 8'h00, 8'h01);
  endtask : t_multi_track_side0

  task automatic t_overrun();
    start(8'h06, 8'h00, 8'h01, 8'h00, 8'h06, 8'h00, 8'h09, 8'hFF);
    fork
      drv.sector('{8'h01, 8'h00, 8'h06, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
      begin
        wait (pushes >= 10);
        @(posedge clk);
        fifo_full <= 1'b1;
      end
    join
    @(posedge clk);
    fifo_full <= 1'b0;
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h00);
    chk("push_count", 8'h0C, pushes[7:0]);
    chk_id(8'h01, 8'h00, 8'h07);
  endtask : t_overrun

  task automatic t_track_errors();
    start(8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h02, 8'hFF);
    drv.index_mark();
    drv.sector('{8'h01, 8'h00, 8'h05, 8'h01}, 1'b1, 1'b0, 256, 1'b0);
    drv.sector('{8'h01, 8'h00, 8'h02, 8'h01}, 1'b1, 1'b0, 256, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h24, 8'h00);
    chk("push_count", 8'h01, {7'h00, pushes == 512});
    repeat (8) @(posedge clk);
  endtask : t_track_errors

  task automatic t_read_deleted_skip();
    start(8'h2C, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h02, 8'h08);
    drv.sector('{8'h01, 8'h00, 8'h01, 8'h00}, 1'b1, 1'b0, 128, 1'b1);
    drv.sector('{8'h01, 8'h00, 8'h02, 8'h00}, 1'b1, 1'b1, 128, 1'b1);
    chk_res(frce_pkg::IC_OK, 8'h00, 8'h40);
    chk("push_count", 8'h08, pushes[7:0]);
    chk_id(8'h02, 8'h00, 8'h01);
  endtask : t_read_deleted_skip

  task automatic t_head_unload();
    @(negedge clk);
    chk("head_load", 8'h01, {7'h00, head_load});
    repeat (40) @(negedge clk);
    chk("head_load", 8'h00, {7'h00, head_load});
  endtask : t_head_unload

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_short_dtl();
    t_multi_sector();
    t_data_crc();
    t_no_data();
    t_deleted_noskip();
    t_terminal_count();
    t_overrun();
    t_track_missing();
    t_track_errors();
    t_read_deleted_skip();
    t_seek_fail();
    t_multi_track_head1();
    t_multi_track_side0();
    t_head_unload();
    close_out();
  end
endmodule : tb
